// >>> rtl/tx_fifo_direct_write_port.sv
`include "txdp_cfg.svh"

module tx_fifo_direct_write_port (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Host bus pins
    input wire logic CHIP_SELECT_N,
    input wire logic WRITE_STROBE_N,
    input wire logic FIFO_SEL,
    input wire logic [`TXDP_ADDR_HI:`TXDP_ADDR_LO] ADDR,
    input wire logic [`TXDP_DATA_W-1:0] DATA,
    // Configuration
    input wire logic BUS_16BIT,
    // Transmit data stream
    input wire logic TXD_READY,
    output logic TXD_VALID,
    output txdp_pkg::tx_word_t TXD_WORD,
    // Status
    output logic TXD_FULL,
    output logic TXD_OVERFLOW,
    output logic REG_WRITE
);
    // ============================================================
    // Pin synchroniser
    // Data and address ride through the same stages as the strobes, so the
    // word seen at the end of a cycle is the one the host held at release.
    txdp_pkg::host_pins_t pins_raw;
    txdp_pkg::host_pins_t sync1_q;
    txdp_pkg::host_pins_t sync2_q;
    txdp_pkg::host_pins_t sync3_q;

    assign pins_raw = '{CHIP_SELECT_N, WRITE_STROBE_N, FIFO_SEL, ADDR, DATA};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= `TXDP_PINS_IDLE;
            sync2_q <= `TXDP_PINS_IDLE;
            sync3_q <= `TXDP_PINS_IDLE;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ============================================================
    // Strobe qualification
    logic both_low2;
    logic both_low3;
    logic engaged_q;
    logic engaged_d;

    assign both_low2 = !sync2_q.chip_select_n && !sync2_q.write_strobe_n;
    assign both_low3 = !sync3_q.chip_select_n && !sync3_q.write_strobe_n;
    // A change counts only once the second and third stages agree.
    assign engaged_d = (both_low2 == both_low3) ? both_low2 : engaged_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            engaged_q <= 1'b0;
        end else begin
            engaged_q <= engaged_d;
        end
    end

    // ============================================================
    // Cycle tracking
    txdp_pkg::cycle_state_t state_q;
    txdp_pkg::cycle_state_t state_d;
    logic fifo_cycle_q;
    txdp_pkg::tx_word_t word_q;
    logic push_valid;
    logic push_ready;

    always_comb begin
        state_d = state_q;
        case (state_q)
            txdp_pkg::ST_IDLE: begin
                if (engaged_d) begin
                    state_d = txdp_pkg::ST_OPEN;
                end
            end
            txdp_pkg::ST_OPEN: begin
                if (!engaged_d) begin
                    state_d = fifo_cycle_q ? txdp_pkg::ST_PUSH : txdp_pkg::ST_IDLE;
                end
            end
            txdp_pkg::ST_PUSH: begin
                state_d = engaged_d ? txdp_pkg::ST_OPEN : txdp_pkg::ST_IDLE;
            end
            default: begin
                state_d = txdp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= txdp_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // The select is sampled once at the start, unlike the address, which is reloaded with the data until release.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fifo_cycle_q <= 1'b0;
        end else if (state_q != txdp_pkg::ST_OPEN && engaged_d) begin
            fifo_cycle_q <= sync3_q.fifo_sel;
        end
    end

    // Data is taken on every cycle the strobes are still low at stage three,
    // so the last load holds the word present just before release.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            word_q <= `TXDP_WORD_RST;
        end else if (state_d == txdp_pkg::ST_OPEN && both_low3) begin
            word_q.data[`TXDP_HALF_W-1:0] <= sync3_q.data[`TXDP_HALF_W-1:0];
            word_q.data[`TXDP_DATA_W-1:`TXDP_HALF_W] <= BUS_16BIT ? '0 :
                sync3_q.data[`TXDP_DATA_W-1:`TXDP_HALF_W];
            // Only the word select survives; the upper address is not decoded.
            word_q.word_sel <= sync3_q.addr[`TXDP_WSEL_HI-1:`TXDP_WSEL_LO-1];
            word_q.narrow <= BUS_16BIT;
        end
    end

    assign push_valid = (state_q == txdp_pkg::ST_PUSH);

    // ============================================================
    // Status pulses
    // The host cannot be stalled, so a push into a full FIFO is dropped and
    // reported; software must watch the full flag.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TXD_OVERFLOW <= 1'b0;
            REG_WRITE <= 1'b0;
        end else begin
            TXD_OVERFLOW <= push_valid && !push_ready;
            REG_WRITE <= (state_q == txdp_pkg::ST_OPEN) && !engaged_d && !fifo_cycle_q;
        end
    end

    assign TXD_FULL = !push_ready;

    // ============================================================
    // Transmit data FIFO
    word_fifo #(
        .WIDTH($bits(txdp_pkg::tx_word_t)),
        .DEPTH(`TXDP_FIFO_DEPTH)
    ) u_fifo (
        .CLK(CLK),
        .RST_N(RST_N),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(word_q),
        .out_ready(TXD_READY),
        .out_valid(TXD_VALID),
        .out_data(TXD_WORD)
    );

    // ============================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    logic [3:0] opens_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            opens_q <= '0;
        end else if (state_q == txdp_pkg::ST_IDLE && state_d == txdp_pkg::ST_OPEN) begin
            opens_q <= opens_q + 4'h1;
        end
    end

    a_start_both_low: assert property (
        $rose(state_q == txdp_pkg::ST_OPEN) |-> $past(both_low3) && $past(both_low2))
        else $error("cycle opened without both strobes low");

    a_open_needs_strobes: assert property (
        !engaged_q |=> state_q != txdp_pkg::ST_OPEN || $past(engaged_d))
        else $error("cycle open while strobes idle");

    a_end_on_release: assert property (
        (state_q == txdp_pkg::ST_OPEN && !engaged_d && fifo_cycle_q)
        |=> state_q == txdp_pkg::ST_PUSH)
        else $error("released fifo cycle did not push");

    a_push_single: assert property (
        push_valid |=> !push_valid)
        else $error("more than one push for one cycle");

    a_push_only_fifo: assert property (
        push_valid |-> fifo_cycle_q)
        else $error("push for a cycle without fifo select");

    a_reg_no_push: assert property (
        REG_WRITE |-> !push_valid && $past(!fifo_cycle_q))
        else $error("plain write routed to fifo");

    a_narrow_upper: assert property (
        push_valid && word_q.narrow |-> word_q.data[31:16] == 16'h0000)
        else $error("upper half kept in 16-bit mode");

    a_push_from_open: assert property (
        push_valid |-> $past(state_q == txdp_pkg::ST_OPEN) ##0 $past(!engaged_d))
        else $error("push without a closed cycle");

    a_overflow_flag: assert property (
        push_valid && !push_ready |=> TXD_OVERFLOW)
        else $error("dropped word not reported");

    a_wsel_track: assert property (
        (state_d == txdp_pkg::ST_OPEN && both_low3)
        |=> word_q.word_sel == $past(sync3_q.addr[1:0]))
        else $error("word select not captured");

    c_fifo_write: cover property (push_valid && push_ready);
    c_overflow: cover property (TXD_OVERFLOW);
    c_reg_write: cover property (REG_WRITE);
    c_back_to_back: cover property (push_valid ##[1:8] push_valid);
    c_many_cycles: cover property (opens_q == 4'hF);
endmodule

// >>> rtl/txdp_cfg.svh
`ifndef TXDP_CFG_SVH
`define TXDP_CFG_SVH
// Behaviour
// - In FIFO write mode upper address is not decoded; writes with select high go to FIFO, writes with select low pulse REG_WRITE.
// - FIFO path used only for writes with select high; select sampled once at cycle start, address taken up to release.
// - Address bits two and one still used; bits seven to three ignored.
// - In 16-bit bus mode upper data half ignored; otherwise modes behave alike.
// - Cycle starts once chip select and write strobe are both low, any order.
// - Cycle ends when either or both strobes release, in any order.

// ============================================================
// Widths and depths
`define TXDP_DATA_W 32
`define TXDP_HALF_W 16
`define TXDP_ADDR_HI 7
`define TXDP_ADDR_LO 1
`define TXDP_WSEL_HI 2
`define TXDP_WSEL_LO 1
`define TXDP_FIFO_DEPTH 16
`define TXDP_SYNC_STAGES 3

// ============================================================
// Reset values
`define TXDP_PINS_IDLE 42'h300_0000_0000
`define TXDP_WORD_RST 35'h0_0000_0000

// ============================================================
// Timing
`define TXDP_CLK_PERIOD_NS 25
`define TXDP_T_CSL_NS 32
`define TXDP_T_CSL_CYC ((`TXDP_T_CSL_NS + `TXDP_CLK_PERIOD_NS - 1) / `TXDP_CLK_PERIOD_NS)
`endif

// >>> rtl/txdp_pkg.sv
package txdp_pkg;
    // Host pins as sampled; order matches the idle reset constant.
    typedef struct packed {
        logic chip_select_n;
        logic write_strobe_n;
        logic fifo_sel;
        logic [6:0] addr;
        logic [31:0] data;
    } host_pins_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0] word_sel;
        logic narrow;
    } tx_word_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OPEN = 3'b010,
        ST_PUSH = 3'b100
    } cycle_state_t;
endpackage

// >>> rtl/word_fifo.sv
module word_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    input wire logic out_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ============================================================
    // Storage
    // The output register holds one word too, so DEPTH-1 live in the array.
    logic [WIDTH-1:0] mem_q [DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic push;
    logic pop;
    logic load_out;

    assign in_ready = (count_q != AW'(DEPTH - 1));
    assign push = in_valid && in_ready;
    assign load_out = (count_q != '0) && (!out_valid_q || out_ready);
    assign pop = load_out;
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 2)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge CLK) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= step(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= step(rd_ptr_q);
            end
            count_q <= count_q + AW'(push) - AW'(pop);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (load_out) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rd_ptr_q];
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end
endmodule

// >>> tb/host_model.sv
// ============================================================
// Host processor bus master
module host_model (
    // Clock
    input wire logic CLK,
    // Host bus pins
    output logic CHIP_SELECT_N,
    output logic WRITE_STROBE_N,
    output logic FIFO_SEL,
    output logic [7:1] ADDR,
    output logic [31:0] DATA
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        CHIP_SELECT_N = 1'b1;
        WRITE_STROBE_N = 1'b1;
        FIFO_SEL = 1'b0;
        ADDR = 7'h00;
        DATA = 32'h0000_0000;
    end

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask

    // ord[0] picks which strobe falls first, ord[1] which rises first.
    // With wr_en low only the chip select moves, so no write cycle forms.
    task automatic cycle(input logic fsel, input logic [7:1] a, input logic [31:0] d,
                         input logic [1:0] ord, input logic wr_en);
        step(1);
        FIFO_SEL = fsel;
        ADDR = a;
        DATA = d;
        if (ord[0]) WRITE_STROBE_N = ~wr_en;
        else CHIP_SELECT_N = 1'b0;
        step(1);
        if (ord[0]) CHIP_SELECT_N = 1'b0;
        else WRITE_STROBE_N = ~wr_en;
        step(4);
        if (ord[1]) CHIP_SELECT_N = 1'b1;
        else WRITE_STROBE_N = 1'b1;
        // Hold time is zero, so stale values must not survive past the cycle end.
        DATA = ~d;
        ADDR = ~a;
        FIFO_SEL = ~fsel;
        step(1);
        CHIP_SELECT_N = 1'b1;
        WRITE_STROBE_N = 1'b1;
        step(4);
    endtask
endmodule

// >>> tb/tx_fifo_direct_write_port_tb.sv
// ============================================================
// Bench top
module tx_fifo_direct_write_port_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic BUS_16BIT = 1'b0;
    logic TXD_READY = 1'b0;
    wire logic cs_n, wr_n, fsel;
    wire logic [7:1] addr;
    wire logic [31:0] data;
    logic TXD_VALID, TXD_FULL, TXD_OVERFLOW, REG_WRITE;
    txdp_pkg::tx_word_t TXD_WORD;
    int err_count = 0;
    int comparisons = 0;
    int reg_cnt = 0;
    int ovf_cnt = 0;

    always #12.5 CLK = ~CLK;

    host_model i_host (.CLK(CLK), .CHIP_SELECT_N(cs_n), .WRITE_STROBE_N(wr_n),
        .FIFO_SEL(fsel), .ADDR(addr), .DATA(data));

    tx_fifo_direct_write_port i_dut (.CLK(CLK), .RST_N(RST_N), .CHIP_SELECT_N(cs_n),
        .WRITE_STROBE_N(wr_n), .FIFO_SEL(fsel), .ADDR(addr), .DATA(data),
        .BUS_16BIT(BUS_16BIT), .TXD_READY(TXD_READY), .TXD_VALID(TXD_VALID),
        .TXD_WORD(TXD_WORD), .TXD_FULL(TXD_FULL), .TXD_OVERFLOW(TXD_OVERFLOW),
        .REG_WRITE(REG_WRITE));

    always @(posedge CLK) begin
        if (REG_WRITE === 1'b1) reg_cnt++;
        if (TXD_OVERFLOW === 1'b1) ovf_cnt++;
    end

    // ============================================================
    // Shared helpers
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [34:0] seen, input logic [34:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask

    function automatic txdp_pkg::tx_word_t mk(input logic n16, input logic [7:1] a,
                                              input logic [31:0] d);
        txdp_pkg::tx_word_t w;
        w.data = n16 ? {16'h0000, d[15:0]} : d;
        w.word_sel = a[2:1];
        w.narrow = n16;
        return w;
    endfunction

    // Checks the head word, then pops it with a one-cycle ready.
    task automatic take(input logic n16, input logic [7:1] a, input logic [31:0] d);
        int i;
        for (i = 0; i < 20 && TXD_VALID !== 1'b1; i++) step(1);
        chk("valid wait", 35'(TXD_VALID), 35'h0_0000_0001);
        if (TXD_VALID !== 1'b1) begin
            close_out();
        end else begin
            chk("word", TXD_WORD, mk(n16, a, d));
            TXD_READY = 1'b1;
            step(1);
            // One edge passes with ready low, so back-to-back pops never re-raise it at once.
            TXD_READY = 1'b0;
            step(1);
        end
    endtask

    // ============================================================
    // Scenarios
    task automatic sc_modes;
        int k, n;
        logic [7:1] a;
        logic [31:0] d;
        n = reg_cnt;
        for (k = 0; k < 8; k++) begin
            BUS_16BIT = k[2];
            a = {5'(k * 7 + 3), 2'(k)};
            d = 32'h9E37_79B9 * (k + 1);
            i_host.cycle(1'b1, a, d, 2'(k), 1'b1);
            take(k[2], a, d);
        end
        chk("reg writes", 35'(reg_cnt), 35'(n));
        BUS_16BIT = 1'b0;
    endtask

    task automatic sc_reg_write;
        int n;
        n = reg_cnt;
        i_host.cycle(1'b0, 7'h2A, 32'h1234_5678, 2'b01, 1'b1);
        step(4);
        chk("reg writes", 35'(reg_cnt), 35'(n + 1));
        chk("valid", 35'(TXD_VALID), 35'h0_0000_0000);
    endtask

    task automatic sc_half;
        int n;
        n = reg_cnt;
        i_host.cycle(1'b1, 7'h06, 32'hDEAD_BEEF, 2'b00, 1'b0);
        step(6);
        chk("valid", 35'(TXD_VALID), 35'h0_0000_0000);
        chk("reg writes", 35'(reg_cnt), 35'(n));
    endtask

    // The drain side stalls until the FIFO refuses, then empties it in order.
    task automatic sc_fill;
        int i, n;
        n = ovf_cnt;
        for (i = 0; i < 17; i++) begin
            i_host.cycle(1'b1, 7'(i * 5), 32'h1000_0000 + i, 2'(i), 1'b1);
            if (i == 14 || i == 15) begin
                step(4);
                chk("full", 35'(TXD_FULL), 35'(i == 15));
            end
        end
        step(4);
        chk("overflow", 35'(ovf_cnt), 35'(n + 1));
        for (i = 0; i < 16; i++) take(1'b0, 7'(i * 5), 32'h1000_0000 + i);
        step(4);
        chk("valid", 35'(TXD_VALID), 35'h0_0000_0000);
        chk("full", 35'(TXD_FULL), 35'h0_0000_0000);
    endtask

    initial begin
        repeat (4) @(posedge CLK);
        #2;
        RST_N = 1'b1;
        step(2);
        sc_modes();
        sc_reg_write();
        sc_half();
        sc_fill();
        close_out();
    end
endmodule
